// ===== rtl/tbm_monitor.sv
// Temperature sensor control and battery monitor top
`timescale 1ns/1ps
module tbm_monitor
    import tbm_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC,
    parameter int ON_CYCLES = ON_CYC
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [2:0] conv_input_sel,
    input wire logic conv_busy,
    input wire logic test_bus_temp,
    input wire logic battery_monitor_en,
    input wire logic battery_irq_en,
    input wire logic sleep_mode,
    input wire logic [11:0] supply_mv,
    output logic temp_sensor_pwr,
    output logic [2:0] temp_scale,
    output logic [3:0] bandgap_trim,
    output logic bandgap_trim_en,
    output logic [7:0] temp_offset,
    output logic conv_start_bit,
    output logic battery_monitor_pwr,
    output logic rc_osc_req,
    output logic battery_low_event,
    output logic irq_line_n
);
    import tbm_pkg::*;
    // -------------------------------------------------------------------
    // Parameter checks
    // -------------------------------------------------------------------
    if (ON_CYCLES < 1 || PERIOD_CYCLES <= ON_CYCLES + 2)
        $error("tbm_monitor: measurement window must fit inside period");
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [7:0] temp_sensor_control; // Range, shift, trim
    logic [7:0] temp_value_offset; // Offset passed to analog
    logic [4:0] battery_threshold; // Low threshold
    logic [4:0] battery_level; // Last measured level
    logic [4:0] next_level; // Quantizer output
    logic [31:0] period_cnt; // Position in 1 s period
    logic [2:0] low_cnt; // Consecutive low readings
    logic battery_low; // Latched low condition
    logic sample; // End of measurement pulse
    logic [4:0] next_level_now; // Code being captured this cycle
    logic [11:0] mv_above; // Supply above the 1.7 V base, in millivolts
    tbm_state_t state; // Measurement window state
    // Register writes; reserved bits of threshold are dropped
    // Writes to the read-only level and to unmapped offsets fall through
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            temp_sensor_control <= RST_TEMP_CTRL; // Shift defaults on [R4]
            temp_value_offset <= RST_TEMP_OFFS;
            battery_threshold <= RST_BAT_THRESH;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_TEMP_CTRL: temp_sensor_control <= reg_wdata;
                ADDR_TEMP_OFFS: temp_value_offset <= reg_wdata;
                ADDR_BAT_THRESH: battery_threshold <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end
    // Read data registered; reads have no side effect [R16]
    // Level reads zero until the first sample after reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                ADDR_TEMP_CTRL: reg_rdata <= temp_sensor_control;
                ADDR_TEMP_OFFS: reg_rdata <= temp_value_offset;
                ADDR_BAT_THRESH: reg_rdata <= {3'h0, battery_threshold};
                ADDR_BAT_LEVEL: reg_rdata <= {3'h0, battery_level}; // Upper bits zero [R10]
                default: reg_rdata <= 8'h00; // Unmapped reads zero
            endcase
        end
    end
    // -------------------------------------------------------------------
    // Temperature sensor control
    // -------------------------------------------------------------------
    // Sensor power follows converter input or test bus routing
    assign temp_sensor_pwr = (conv_input_sel == SEL_TEMP) || test_bus_temp; // [R1]
    // Scale decode; unshifted codes other than 10 are undefined, flagged apart
    always_comb
    begin
        if (temp_sensor_control[SHIFT_BIT])
        begin
            unique case (temp_sensor_control[RANGE_HI:RANGE_LO]) // [R3]
                2'b00: temp_scale = SCALE_C_HALF_A;
                2'b01: temp_scale = SCALE_C_ONE;
                2'b10: temp_scale = SCALE_C_HALF_B;
                default: temp_scale = SCALE_F_ONE;
            endcase
        end
        else if (temp_sensor_control[RANGE_HI:RANGE_LO] == 2'b10)
            temp_scale = SCALE_KELVIN; // Test-only absolute mode [R4]
        else
            temp_scale = SCALE_UNSHIFTED;
    end
    // Trim is only applied while enabled; otherwise the neutral code
    // The neutral code leaves the bandgap at its untrimmed voltage
    assign bandgap_trim_en = temp_sensor_control[TRIM_EN_BIT]; // [R6]
    assign bandgap_trim = temp_sensor_control[TRIM_EN_BIT] ?
        temp_sensor_control[TRIM_HI:0] : 4'h0; // [R6]
    // Offset register passes straight to the analog side
    assign temp_offset = temp_value_offset;
    // Start bit mirrors the converter busy, falling at completion [R15]
    assign conv_start_bit = conv_busy; // [R15]
    // -------------------------------------------------------------------
    // Battery monitor sequencing
    // -------------------------------------------------------------------
    // Period counter; restarts when disabled so the first sample is a full period
    // Trade-off: the window sits at the period end, so the first reading waits a period
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            period_cnt <= 32'h0;
        else if (!battery_monitor_en)
            period_cnt <= 32'h0; // [R7]
        else if (period_cnt == 32'(PERIOD_CYCLES - 1))
            period_cnt <= 32'h0; // [R8]
        else
            period_cnt <= period_cnt + 32'h1;
    end
    // Window state: idle, powered measurement, sample
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= ST_IDLE;
        else if (!battery_monitor_en)
            state <= ST_IDLE; // [R7]
        else
        begin
            unique case (state)
                ST_IDLE: if (period_cnt == 32'(PERIOD_CYCLES - ON_CYCLES - 1)) state <= ST_MEAS;
                ST_MEAS: if (period_cnt == 32'(PERIOD_CYCLES - 1)) state <= ST_DONE; // [R8]
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end
    // Comparator and converter powered only inside the window to save current
    assign battery_monitor_pwr = (state == ST_MEAS); // On about 250 us [R8]
    // Sample falls one cycle after the window so the converter has settled
    assign sample = (state == ST_DONE);
    // Oscillator kept running in sleep while monitoring
    assign rc_osc_req = battery_monitor_en && sleep_mode; // [R9]
    // Level register holds its code between samples
    tbm_quantizer u_quant (
        .clk(clk),
        .sys_rst(sys_rst),
        .sample(sample && battery_monitor_en),
        .supply_mv(supply_mv),
        .level(next_level)
    );
    assign battery_level = next_level; // Updated only at window end [R16]
    // -------------------------------------------------------------------
    // Low battery detection
    // -------------------------------------------------------------------
    // Consecutive low counter; a good reading restarts it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            low_cnt <= 3'h0;
            battery_low <= 1'b0;
        end
        else if (!battery_monitor_en)
        begin
            low_cnt <= 3'h0;
            battery_low <= 1'b0;
        end
        else if (sample)
        begin
            // Quantizer captures this same edge, so compare the new code directly
            if (next_level_now < battery_threshold) // [R12]
            begin
                if (low_cnt < 3'(LOW_COUNT))
                    low_cnt <= low_cnt + 3'h1;
                if (low_cnt == 3'(LOW_COUNT - 1))
                    battery_low <= 1'b1; // Fourth consecutive low [R13]
            end
            else
            begin
                low_cnt <= 3'h0; // [R13]
                battery_low <= 1'b0;
            end
        end
    end
    // Same coding as the quantizer, combinational so the compare sees this sample
    assign mv_above = supply_mv - 12'(LEVEL_BASE_MV);
    assign next_level_now = (supply_mv < 12'(LEVEL_BASE_MV)) ? 5'h00 :
        ((mv_above / 12'(LEVEL_STEP_MV)) >= 12'(LEVEL_MAX) - 12'h001) ? LEVEL_MAX :
        5'(mv_above / 12'(LEVEL_STEP_MV) + 12'h001);
    // One-cycle event when the low condition first becomes true
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            battery_low_event <= 1'b0;
        else
            battery_low_event <= sample && battery_monitor_en &&
                (next_level_now < battery_threshold) && (low_cnt == 3'(LOW_COUNT - 1));
    end
    // -------------------------------------------------------------------
    // Interrupt output
    // -------------------------------------------------------------------
    // A level, not a pulse: it stays low until a good reading or a disable
    // Interrupt line low only while condition holds and source enabled [R14]
    assign irq_line_n = !(battery_low && battery_irq_en); // [R14]
endmodule

// ===== rtl/tbm_pkg.sv
// Package with register map, field layout, reset values and timing for the monitor
//
// Function
// [R1] Sensor powered when converter selects it or bus
// [R2] Host selects 000, ref 00, range, shift, start
// [R3] Range field maps four shifted scales
// [R4] Shift off, range 10 gives kelvin test mode
// [R5] Host scales result by step plus range minimum
// [R6] Trim enable applies 4-bit bandgap trim
// [R7] Battery monitor runs only while enabled
// [R8] Measure every 1 s for about 250 us
// [R9] Enabled in sleep starts RC oscillator
// [R10] 5-bit level readable, upper three bits zero
// [R11] Level steps 50 mV from 1.7 V
// [R12] Level below threshold means battery low
// [R13] Interrupt after four consecutive low readings
// [R14] Drive interrupt line only when source enabled
// [R15] Start bit self-clears at conversion end
// [R16] Level updates only at measurement end
package tbm_pkg;
    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [6:0] ADDR_TEMP_CTRL = 7'h12;
    localparam logic [6:0] ADDR_TEMP_OFFS = 7'h13;
    localparam logic [6:0] ADDR_BAT_THRESH = 7'h1a;
    localparam logic [6:0] ADDR_BAT_LEVEL = 7'h1b;
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_TEMP_CTRL = 8'h20;
    localparam logic [7:0] RST_TEMP_OFFS = 8'h00;
    localparam logic [4:0] RST_BAT_THRESH = 5'h14;
    // -------------------------------------------------------------------
    // Field positions in temp_sensor_control
    // -------------------------------------------------------------------
    localparam int RANGE_HI = 7;
    localparam int RANGE_LO = 6;
    localparam int SHIFT_BIT = 5;
    localparam int TRIM_EN_BIT = 4;
    localparam int TRIM_HI = 3;
    // Converter input code for the temperature sensor
    localparam logic [2:0] SEL_TEMP = 3'h0;
    // Analog scale selections
    localparam logic [2:0] SCALE_C_HALF_A = 3'h0;
    localparam logic [2:0] SCALE_C_ONE = 3'h1;
    localparam logic [2:0] SCALE_C_HALF_B = 3'h2;
    localparam logic [2:0] SCALE_F_ONE = 3'h3;
    localparam logic [2:0] SCALE_KELVIN = 3'h4;
    localparam logic [2:0] SCALE_UNSHIFTED = 3'h5;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int MEAS_PERIOD_MS = 1000;
    localparam int MEAS_ON_US = 250;
    localparam int PERIOD_CYC = CLK_HZ / 1000 * MEAS_PERIOD_MS;
    localparam int ON_CYC = CLK_HZ / 1_000_000 * MEAS_ON_US;
    localparam int LOW_COUNT = 4;
    // Level coding: 1.7 V base, 50 mV per count
    localparam int LEVEL_BASE_MV = 1700;
    localparam int LEVEL_STEP_MV = 50;
    localparam logic [4:0] LEVEL_MAX = 5'h1f;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEAS = 2'b01,
        ST_DONE = 2'b11
    } tbm_state_t;
endpackage

// ===== rtl/tbm_quantizer.sv
// Supply voltage to 5-bit level quantizer
`timescale 1ns/1ps
module tbm_quantizer
    import tbm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample,
    input wire logic [11:0] supply_mv,
    output logic [4:0] level
);
    // -------------------------------------------------------------------
    // Registered conversion
    // -------------------------------------------------------------------
    localparam logic [11:0] BASE = 12'(LEVEL_BASE_MV);
    localparam logic [11:0] STEP = 12'(LEVEL_STEP_MV);
    logic [11:0] above; // Millivolts above the base
    logic [11:0] steps; // Whole steps above the base
    assign above = supply_mv - BASE;
    assign steps = above / STEP;
    // Capture only on the sample pulse so the level is stable between samples
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            level <= 5'h00;
        else if (sample)
        begin
            if (supply_mv < BASE)
                level <= 5'h00; // Below 1.7 V [R11]
            else if (steps >= 12'(LEVEL_MAX) - 12'h001)
                level <= LEVEL_MAX; // Saturate at top code [R11]
            else
                level <= 5'(steps + 12'h001); // Code n covers 1.7 V + 50 mV x (n - 1) up to the next step [R11]
        end
    end
endmodule

// ===== tb/tbm_conv_model.sv
// Behavioural model of the converter and host selecting its input
`timescale 1ns/1ps
module tbm_conv_model
    import tbm_pkg::*;
#(
    parameter int CONV_CYC = 35000
)
(
    input wire logic clk,
    input wire logic go,
    input wire logic [2:0] sel_req,
    output logic [2:0] conv_input_sel,
    output logic conv_busy
);
    int cnt = 0; // Cycles left in the running conversion
    // Host sets the input code before starting a conversion
    always_ff @(posedge clk)
        conv_input_sel <= sel_req;
    // A start loads the conversion time, then counts down
    always_ff @(posedge clk)
        cnt <= go ? CONV_CYC : (cnt > 0 ? cnt - 1 : 0);
    assign conv_busy = (cnt > 0);
endmodule

// ===== tb/tbm_monitor_chk.sv
// Concurrent checks on the monitor top ports
`timescale 1ns/1ps
module tbm_chk
    import tbm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] conv_input_sel,
    input wire logic conv_busy,
    input wire logic test_bus_temp,
    input wire logic battery_monitor_en,
    input wire logic battery_irq_en,
    input wire logic sleep_mode,
    input wire logic temp_sensor_pwr,
    input wire logic [3:0] bandgap_trim,
    input wire logic bandgap_trim_en,
    input wire logic conv_start_bit,
    input wire logic battery_monitor_pwr,
    input wire logic rc_osc_req,
    input wire logic battery_low_event,
    input wire logic irq_line_n
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_pwr;
        temp_sensor_pwr == (conv_input_sel == SEL_TEMP || test_bus_temp);
    endproperty
    property p_rc;
        rc_osc_req == (battery_monitor_en && sleep_mode);
    endproperty
    property p_start;
        conv_start_bit == conv_busy;
    endproperty
    property p_irq;
        !irq_line_n |-> battery_irq_en;
    endproperty
    property p_hi;
        reg_rd && reg_addr == ADDR_BAT_LEVEL |=> reg_rdata[7:5] == 3'h0;
    endproperty
    // Power may lag the enable by one cycle, never by two
    property p_off;
        !battery_monitor_en ##1 !battery_monitor_en |-> !battery_monitor_pwr;
    endproperty
    property p_ev;
        battery_low_event |=> !battery_low_event;
    endproperty
    property p_trim;
        !bandgap_trim_en |-> bandgap_trim == 4'h0;
    endproperty
    // Event and latch rise together, so the line is low while the event shows
    property p_evirq;
        battery_low_event && battery_irq_en |-> !irq_line_n;
    endproperty
    a_pwr: assert property (p_pwr) else $error("sensor power wrong");
    a_rc: assert property (p_rc) else $error("rc request wrong");
    a_start: assert property (p_start) else $error("start bit wrong");
    a_irq: assert property (p_irq) else $error("irq while masked");
    a_hi: assert property (p_hi) else $error("level upper bits set");
    a_off: assert property (p_off) else $error("monitor powered while off");
    a_ev: assert property (p_ev) else $error("event not a pulse");
    a_trim: assert property (p_trim) else $error("trim applied while off");
    a_evirq: assert property (p_evirq) else $error("event without interrupt");
    c_ev: cover property (battery_low_event);
    c_irq: cover property (!irq_line_n);
    c_meas: cover property ($rose(battery_monitor_pwr));
endmodule
bind tbm_monitor tbm_chk u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .conv_input_sel(conv_input_sel),
    .conv_busy(conv_busy),
    .test_bus_temp(test_bus_temp),
    .battery_monitor_en(battery_monitor_en),
    .battery_irq_en(battery_irq_en),
    .sleep_mode(sleep_mode),
    .temp_sensor_pwr(temp_sensor_pwr),
    .bandgap_trim(bandgap_trim),
    .bandgap_trim_en(bandgap_trim_en),
    .conv_start_bit(conv_start_bit),
    .battery_monitor_pwr(battery_monitor_pwr),
    .rc_osc_req(rc_osc_req),
    .battery_low_event(battery_low_event),
    .irq_line_n(irq_line_n)
);

// ===== tb/tbm_monitor_test.sv
// Self-checking testbench for the monitor top
`timescale 1ns/1ps
module tbm_monitor_test;
    import tbm_pkg::*;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, go = 0, test_bus_temp = 0;
    logic battery_monitor_en = 0, battery_irq_en = 0, sleep_mode = 0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, temp_offset, v;
    logic [2:0] sel_req = 3'h0, conv_input_sel, temp_scale;
    logic [11:0] supply_mv = 12'hce4;
    logic conv_busy, temp_sensor_pwr, bandgap_trim_en, conv_start_bit, battery_monitor_pwr;
    logic rc_osc_req, battery_low_event, irq_line_n;
    logic [3:0] bandgap_trim;
    int err_count = 0, n_compared = 0, cyc = 0, lows = 0, n_events = 0, mv, t;
    always #5 clk = ~clk;
    // Short period and window keep the run brief
    tbm_monitor #(.PERIOD_CYCLES(40), .ON_CYCLES(5)) u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .conv_input_sel(conv_input_sel),
        .conv_busy(conv_busy),
        .test_bus_temp(test_bus_temp),
        .battery_monitor_en(battery_monitor_en),
        .battery_irq_en(battery_irq_en),
        .sleep_mode(sleep_mode),
        .supply_mv(supply_mv),
        .temp_sensor_pwr(temp_sensor_pwr),
        .temp_scale(temp_scale),
        .bandgap_trim(bandgap_trim),
        .bandgap_trim_en(bandgap_trim_en),
        .temp_offset(temp_offset),
        .conv_start_bit(conv_start_bit),
        .battery_monitor_pwr(battery_monitor_pwr),
        .rc_osc_req(rc_osc_req),
        .battery_low_event(battery_low_event),
        .irq_line_n(irq_line_n)
    );
    tbm_conv_model #(.CONV_CYC(2)) u_conv (
        .clk(clk),
        .go(go),
        .sel_req(sel_req),
        .conv_input_sel(conv_input_sel),
        .conv_busy(conv_busy)
    );
    // Count low-battery event pulses as the design shows them
    always @(posedge clk)
    begin
        if (battery_low_event === 1'b1)
            n_events++;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(string name, logic [11:0] seen, logic [11:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // Each access idles one cycle so strobes never toggle twice at once
    task automatic wr(logic [6:0] a, logic [7:0] d);
        reg_wr = 1; reg_addr = a; reg_wdata = d;
        @(posedge clk) #1 reg_wr = 0;
        @(posedge clk) #1;
    endtask
    task automatic rd(logic [6:0] a);
        reg_rd = 1; reg_addr = a;
        @(posedge clk) #1 reg_rd = 0;
        v = reg_rdata;
        @(posedge clk) #1;
    endtask
    function automatic int lvl(int m);
        return m < 1700 ? 0 : ((m - 1700) / 50 + 1 > 31 ? 31 : (m - 1700) / 50 + 1);
    endfunction
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            stop_test;
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        t = $urandom(32'h6d16d8fc);
        repeat (2) @(posedge clk);
        #1 sys_rst = 0;
        rd(ADDR_TEMP_CTRL); chk("ctrl", v, RST_TEMP_CTRL);
        rd(ADDR_TEMP_OFFS); chk("offs", v, RST_TEMP_OFFS);
        rd(ADDR_BAT_THRESH); chk("thr", v, {3'h0, RST_BAT_THRESH});
        wr(7'h7f, 8'hff); rd(7'h7f); chk("unmapped", v, 8'h00);
        // Each shifted range selects its scale, with trim enabled at a random code
        for (int r = 0; r < 4; r++)
        begin
            t = $urandom_range(0, 15);
            wr(ADDR_TEMP_CTRL, {r[1:0], 2'b11, t[3:0]});
            chk("scale", temp_scale, r[2:0]);
            chk("trim", bandgap_trim, t[3:0]);
            chk("trim_en", bandgap_trim_en, 1'b1);
        end
        wr(ADDR_TEMP_CTRL, 8'h80); chk("kelvin", temp_scale, SCALE_KELVIN);
        chk("trim_off", bandgap_trim, 4'h0);
        chk("trim_en_off", bandgap_trim_en, 1'b0);
        wr(ADDR_TEMP_CTRL, 8'h40); chk("unshift", temp_scale, SCALE_UNSHIFTED);
        t = $urandom; wr(ADDR_TEMP_OFFS, t[7:0]); rd(ADDR_TEMP_OFFS);
        chk("offs_rw", v, t[7:0]);
        chk("offs_out", temp_offset, t[7:0]);
        wr(ADDR_BAT_THRESH, 8'hf0); rd(ADDR_BAT_THRESH); chk("thr_rw", v, 8'h10);
        wr(ADDR_BAT_LEVEL, 8'hff); rd(ADDR_BAT_LEVEL); chk("lvl_ro", v, 8'h00);
        // Every input code, then the test bus route alone
        for (int s = 0; s < 9; s++)
        begin
            sel_req = (s == 8) ? 3'h5 : s[2:0]; test_bus_temp = (s == 8);
            @(posedge clk) #1 go = (s == 0);
            @(posedge clk) #1 chk("tpwr", temp_sensor_pwr, s == 0 || s == 8);
            chk("busy", conv_start_bit, s == 0);
            go = 0;
        end
        // Threshold 16; one high reading restarts the low count
        battery_monitor_en = 1; battery_irq_en = 1; sleep_mode = 1;
        repeat (20) @(posedge clk);
        #1 chk("rc", rc_osc_req, 1'b1);
        for (int i = 0; i < 7; i++)
        begin
            mv = (i == 2) ? 3000 : $urandom_range(1500, 2440);
            supply_mv = mv[11:0];
            repeat (38) @(posedge clk);
            #1 lows = (lvl(mv) < 16) ? lows + 1 : 0;
            rd(ADDR_BAT_LEVEL); chk("level", v, lvl(mv));
            chk("irq", irq_line_n, lows < 4);
        end
        chk("events", 12'(n_events), 12'h001);
        battery_irq_en = 0;
        #1 chk("irq_mask", irq_line_n, 1'b1);
        battery_monitor_en = 0; sleep_mode = 0;
        repeat (45) @(posedge clk);
        #1 chk("pwr_off", battery_monitor_pwr, 1'b0);
        stop_test;
    end
endmodule
